/* File: logic/link_slot_regs.sv */
// Link capability, link status/control and slot capability register bank
`timescale 1ns/10ps
// Overview of operation
// R1: L0s exit latency reads 000, read-only
// R2: ASPM support field fixed at 01
// R3: Max width x4 instance zero, x1 others
// R4: Max link speed reads 1, read-only
// R5: Bit 29 shows data link active state
// R6: Slot clock bit local-writable, link read-only
// R7: Bit 27 high during link training
// R8: Negotiated width in bits 25:20, reset 000001
// R9: Negotiated link speed reads 1
// R10: Clock PM enable link-written, zero without capability
// R11: Extended sync bit drives extra ordered sets
// R12: Common clock bit feeds exit latency logic
// R13: Writing 1 retrains link, root port only; reads 0
// R14: Writing 1 disables link, root port only
// R15: RCB root reads 1, endpoint writable
// R16: ASPM control field, 00 off, 01 L0s
// R17: Reserved bits read as zero
// R18: Slot capability local-writable, link read-only
// R19: Slot number programmed by software, resets zero
// R20: Command-complete bit set by software
// R21: Power scale write sends power message
// R22: Power value in bits 14:7, sends message
// R23: Hot plug presence bits set by software
// R24: Capability bit 20 enables active reporting
// R25: Active-state change sets sticky flag, cleared by dll_changed_clear
// R26: One power message per modifying write
module link_slot_regs #(
  parameter int INSTANCE = 0
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic root_port_mode,
  input wire logic [1:0] lcl_sel,
  input wire logic lcl_wr,
  input wire logic lcl_rd,
  input wire logic [31:0] lcl_wdata,
  output logic [31:0] lcl_rdata,
  input wire logic [1:0] cfg_sel,
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  input wire logic [31:0] cfg_wdata,
  output logic [31:0] cfg_rdata,
  input wire logic dl_active,
  input wire logic link_training,
  input wire logic [5:0] negotiated_width,
  input wire logic clock_pm_capable,
  input wire logic dll_changed_clear,
  output logic dll_changed_flag,
  output logic retrain_pulse,
  output logic link_disable,
  output logic ext_sync_en,
  output logic common_clk_en,
  output logic clock_pm_en,
  output logic [1:0] aspm_ctl,
  output logic rcb_128,
  output logic slot_clk_cfg,
  output logic [31:0] slot_cap,
  output logic slot_power_msg
);
  logic [7:0] port_num_reg;
  logic dll_cap_reg;
  logic slot_clk_reg;
  logic clk_pm_en_reg;
  logic ext_sync_reg;
  logic common_clk_reg;
  logic link_dis_reg;
  logic rcb_reg;
  logic [1:0] aspm_reg;
  logic [31:0] slot_cap_reg;
  logic [5:0] neg_width_reg;
  logic dl_seen_reg;
  logic dll_changed_reg;
  logic retrain_reg;
  logic msg_reg;
  logic [31:0] lcl_rdata_reg;
  logic [31:0] cfg_rdata_reg;
  logic [31:0] link_cap_word;
  logic [31:0] link_sc_word;
  logic [5:0] max_width;
  logic dl_reported;
  logic lcl_wr_lsc;
  logic cfg_wr_lsc;
  localparam int PWR_W = link_slot_pkg::PWR_FIELDS_W;
  logic [PWR_W-1:0] pwr_new;

  assign max_width = (INSTANCE == 0) ? link_slot_pkg::WIDTH_X4 : link_slot_pkg::WIDTH_X1; // R3
  assign dl_reported = dl_active & dll_cap_reg; // R5 R24
  assign lcl_wr_lsc = lcl_wr && (lcl_sel == link_slot_pkg::SEL_LINK_STAT_CTL);
  assign cfg_wr_lsc = cfg_wr && (cfg_sel == link_slot_pkg::SEL_LINK_STAT_CTL);
  assign pwr_new = lcl_wdata[link_slot_pkg::PWR_FIELDS_LSB +: PWR_W];

  // ------------------------------------------------------------
  // Read words
  // ------------------------------------------------------------
  always_comb begin
    link_cap_word = 32'h0000_0000; // R17
    link_cap_word[link_slot_pkg::PORT_NUM_LSB +: link_slot_pkg::PORT_NUM_W] = port_num_reg;
    link_cap_word[link_slot_pkg::DLL_REPORT_CAP_BIT] = dll_cap_reg; // R24
    link_cap_word[link_slot_pkg::CLK_PM_CAP_BIT] = clock_pm_capable;
    link_cap_word[link_slot_pkg::L1_EXIT_LSB +: 3] = link_slot_pkg::L1_EXIT_VAL;
    link_cap_word[link_slot_pkg::L0S_EXIT_LSB +: 3] = link_slot_pkg::L0S_EXIT_VAL; // R1
    link_cap_word[link_slot_pkg::ASPM_SUP_LSB +: 2] = link_slot_pkg::ASPM_SUP_VAL; // R2
    link_cap_word[link_slot_pkg::MAX_WIDTH_LSB +: 6] = max_width; // R3
    link_cap_word[link_slot_pkg::MAX_SPEED_LSB +: 4] = link_slot_pkg::SPEED_2G5; // R4
  end

  always_comb begin
    link_sc_word = 32'h0000_0000; // R17
    link_sc_word[link_slot_pkg::DL_ACTIVE_BIT] = dl_reported; // R5
    link_sc_word[link_slot_pkg::SLOT_CLK_BIT] = slot_clk_reg; // R6
    link_sc_word[link_slot_pkg::TRAINING_BIT] = link_training; // R7
    link_sc_word[link_slot_pkg::NEG_WIDTH_LSB +: 6] = neg_width_reg; // R8
    link_sc_word[link_slot_pkg::NEG_SPEED_LSB +: 4] = link_slot_pkg::SPEED_2G5; // R9
    link_sc_word[link_slot_pkg::CLK_PM_EN_BIT] = clk_pm_en_reg;
    link_sc_word[link_slot_pkg::EXT_SYNC_BIT] = ext_sync_reg;
    link_sc_word[link_slot_pkg::COMMON_CLK_BIT] = common_clk_reg;
    link_sc_word[link_slot_pkg::RETRAIN_BIT] = 1'b0; // R13
    link_sc_word[link_slot_pkg::LINK_DIS_BIT] = link_dis_reg;
    link_sc_word[link_slot_pkg::RCB_BIT] = root_port_mode | rcb_reg; // R15
    link_sc_word[link_slot_pkg::ASPM_CTL_LSB +: 2] = aspm_reg;
  end

  function automatic logic [31:0] pick(input logic [1:0] sel, input logic [31:0] a,
                                       input logic [31:0] b, input logic [31:0] c);
    case (sel)
      link_slot_pkg::SEL_LINK_CAP: pick = a;
      link_slot_pkg::SEL_LINK_STAT_CTL: pick = b;
      link_slot_pkg::SEL_SLOT_CAP: pick = c;
      default: pick = 32'h0000_0000; // R17
    endcase
  endfunction

  // ------------------------------------------------------------
  // Read ports
  // ------------------------------------------------------------
  // Read data holds until the next read on that port
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      lcl_rdata_reg <= 32'h0000_0000;
    end else if (lcl_rd) begin
      lcl_rdata_reg <= pick(lcl_sel, link_cap_word, link_sc_word, slot_cap_reg);
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      cfg_rdata_reg <= 32'h0000_0000;
    end else if (cfg_rd) begin
      cfg_rdata_reg <= pick(cfg_sel, link_cap_word, link_sc_word, slot_cap_reg);
    end
  end

  // ------------------------------------------------------------
  // Link capability, local side only
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      port_num_reg <= 8'h00;
      dll_cap_reg <= 1'b0;
    end else if (lcl_wr && (lcl_sel == link_slot_pkg::SEL_LINK_CAP)) begin
      port_num_reg <= lcl_wdata[link_slot_pkg::PORT_NUM_LSB +: link_slot_pkg::PORT_NUM_W];
      dll_cap_reg <= lcl_wdata[link_slot_pkg::DLL_REPORT_CAP_BIT]; // R24
    end
  end

  // ------------------------------------------------------------
  // Link control
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      slot_clk_reg <= 1'b0;
    end else if (lcl_wr_lsc) begin
      slot_clk_reg <= lcl_wdata[link_slot_pkg::SLOT_CLK_BIT]; // R6
    end
  end

  // Link side wins when both sides write in one cycle
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ext_sync_reg <= 1'b0;
      common_clk_reg <= 1'b0;
    end else if (cfg_wr_lsc || lcl_wr_lsc) begin
      ext_sync_reg <= cfg_wr_lsc ? cfg_wdata[link_slot_pkg::EXT_SYNC_BIT]
                                 : lcl_wdata[link_slot_pkg::EXT_SYNC_BIT]; // R11
      common_clk_reg <= cfg_wr_lsc ? cfg_wdata[link_slot_pkg::COMMON_CLK_BIT]
                                   : lcl_wdata[link_slot_pkg::COMMON_CLK_BIT]; // R12
    end
  end

  // Stored in both modes; only the output is gated by root port mode
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      link_dis_reg <= 1'b0;
    end else if (cfg_wr_lsc || lcl_wr_lsc) begin
      link_dis_reg <= cfg_wr_lsc ? cfg_wdata[link_slot_pkg::LINK_DIS_BIT]
                                 : lcl_wdata[link_slot_pkg::LINK_DIS_BIT]; // R14
    end
  end

  // Root port pins the boundary at 128 bytes, so writes count only as endpoint
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rcb_reg <= 1'b0;
    end else if ((cfg_wr_lsc || lcl_wr_lsc) && !root_port_mode) begin
      rcb_reg <= cfg_wr_lsc ? cfg_wdata[link_slot_pkg::RCB_BIT]
                            : lcl_wdata[link_slot_pkg::RCB_BIT]; // R15
    end
  end

  // Prohibited codes are kept as written; software must not use them
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      aspm_reg <= link_slot_pkg::ASPM_CTL_RESET;
    end else if (cfg_wr_lsc || lcl_wr_lsc) begin
      aspm_reg <= cfg_wr_lsc ? cfg_wdata[link_slot_pkg::ASPM_CTL_LSB +: 2]
                             : lcl_wdata[link_slot_pkg::ASPM_CTL_LSB +: 2]; // R16
    end
  end

  // Without the capability the enable is forced low, stored value too
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      clk_pm_en_reg <= 1'b0;
    end else if (!clock_pm_capable) begin
      clk_pm_en_reg <= 1'b0; // R10
    end else if (cfg_wr_lsc) begin
      clk_pm_en_reg <= cfg_wdata[link_slot_pkg::CLK_PM_EN_BIT]; // R10
    end
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      retrain_reg <= 1'b0;
    end else begin
      retrain_reg <= root_port_mode &&
                     ((cfg_wr_lsc && cfg_wdata[link_slot_pkg::RETRAIN_BIT]) ||
                      (lcl_wr_lsc && lcl_wdata[link_slot_pkg::RETRAIN_BIT])); // R13
    end
  end

  // ------------------------------------------------------------
  // Link status tracking
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      neg_width_reg <= link_slot_pkg::NEG_WIDTH_RESET;
    end else begin
      neg_width_reg <= negotiated_width; // R8
    end
  end

  // Set beats clear so a change in the clearing cycle is kept
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      dl_seen_reg <= 1'b0;
      dll_changed_reg <= 1'b0;
    end else begin
      dl_seen_reg <= dl_reported;
      if (dl_reported != dl_seen_reg) begin
        dll_changed_reg <= 1'b1; // R25
      end else if (dll_changed_clear) begin
        dll_changed_reg <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // Slot capability, stored, with power message on power field change
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      slot_cap_reg <= link_slot_pkg::SLOT_CAP_RESET;
    end else if (lcl_wr && (lcl_sel == link_slot_pkg::SEL_SLOT_CAP)) begin
      slot_cap_reg <= lcl_wdata; // R18 R19 R20 R23
    end
  end

  // Both power fields share one compare, so one message per modifying write
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      msg_reg <= 1'b0;
    end else begin
      msg_reg <= lcl_wr && (lcl_sel == link_slot_pkg::SEL_SLOT_CAP) &&
                 (pwr_new != slot_cap_reg[link_slot_pkg::PWR_FIELDS_LSB +: PWR_W]); // R21 R22 R26
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign lcl_rdata = lcl_rdata_reg;
  assign cfg_rdata = cfg_rdata_reg;
  assign dll_changed_flag = dll_changed_reg;
  assign retrain_pulse = retrain_reg;
  assign link_disable = link_dis_reg & root_port_mode; // R14
  assign ext_sync_en = ext_sync_reg; // R11
  assign common_clk_en = common_clk_reg; // R12
  assign clock_pm_en = clk_pm_en_reg;
  assign aspm_ctl = aspm_reg;
  assign rcb_128 = root_port_mode | rcb_reg;
  assign slot_clk_cfg = slot_clk_reg;
  assign slot_cap = slot_cap_reg;
  assign slot_power_msg = msg_reg;
endmodule

/* File: logic/link_slot_pkg.sv */
// Constants for the link and slot capability register bank
package link_slot_pkg;
  // ------------------------------------------------------------
  // Register selects
  // ------------------------------------------------------------
  localparam logic [1:0] SEL_LINK_CAP = 2'h0;
  localparam logic [1:0] SEL_LINK_STAT_CTL = 2'h1;
  localparam logic [1:0] SEL_SLOT_CAP = 2'h2;

  // ------------------------------------------------------------
  // Link capability fields
  // ------------------------------------------------------------
  localparam int PORT_NUM_LSB = 24;
  localparam int PORT_NUM_W = 8;
  localparam int DLL_REPORT_CAP_BIT = 20;
  localparam int CLK_PM_CAP_BIT = 18;
  localparam int L1_EXIT_LSB = 15;
  localparam logic [2:0] L1_EXIT_VAL = 3'h4;
  localparam int L0S_EXIT_LSB = 12;
  localparam logic [2:0] L0S_EXIT_VAL = 3'h0;
  localparam int ASPM_SUP_LSB = 10;
  localparam logic [1:0] ASPM_SUP_VAL = 2'h1;
  localparam int MAX_WIDTH_LSB = 4;
  localparam logic [5:0] WIDTH_X4 = 6'h04;
  localparam logic [5:0] WIDTH_X1 = 6'h01;
  localparam int MAX_SPEED_LSB = 0;
  localparam logic [3:0] SPEED_2G5 = 4'h1;

  // ------------------------------------------------------------
  // Link status / control fields
  // ------------------------------------------------------------
  localparam int DL_ACTIVE_BIT = 29;
  localparam int SLOT_CLK_BIT = 28;
  localparam int TRAINING_BIT = 27;
  localparam int NEG_WIDTH_LSB = 20;
  localparam logic [5:0] NEG_WIDTH_RESET = 6'h01;
  localparam int NEG_SPEED_LSB = 16;
  localparam int CLK_PM_EN_BIT = 8;
  localparam int EXT_SYNC_BIT = 7;
  localparam int COMMON_CLK_BIT = 6;
  localparam int RETRAIN_BIT = 5;
  localparam int LINK_DIS_BIT = 4;
  localparam int RCB_BIT = 3;
  localparam int ASPM_CTL_LSB = 0;
  localparam logic [1:0] ASPM_CTL_RESET = 2'h0;

  // ------------------------------------------------------------
  // Slot capability fields
  // ------------------------------------------------------------
  localparam int PWR_FIELDS_LSB = 7;
  localparam int PWR_FIELDS_W = 10;
  localparam logic [31:0] SLOT_CAP_RESET = 32'h0000_0000;
endpackage

/* File: sim/link_slot_regs_checker.sv */
// Port-level assertions for the link and slot register bank
`timescale 1ns/10ps
module link_slot_regs_checker (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic root_port_mode,
  input wire logic [1:0] lcl_sel,
  input wire logic lcl_wr,
  input wire logic lcl_rd,
  input wire logic [31:0] lcl_wdata,
  input wire logic [31:0] lcl_rdata,
  input wire logic cfg_wr,
  input wire logic clock_pm_capable,
  input wire logic dll_changed_clear,
  input wire logic dll_changed_flag,
  input wire logic retrain_pulse,
  input wire logic link_disable,
  input wire logic clock_pm_en,
  input wire logic rcb_128,
  input wire logic slot_clk_cfg,
  input wire logic [31:0] slot_cap,
  input wire logic slot_power_msg
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  // ----
  // Assertions
  // ----
  a_retrain_fire: assert property (
    lcl_wr && lcl_sel == 2'h1 && lcl_wdata[5] && root_port_mode
    |=> retrain_pulse ##1 !retrain_pulse) else $error("retrain pulse wrong");
  a_disable_gated: assert property (
    !root_port_mode |-> !link_disable) else $error("link disable outside root mode");
  a_rcb_root: assert property (
    root_port_mode |-> rcb_128) else $error("rcb not fixed in root mode");
  a_clkpm_held: assert property (
    !clock_pm_capable && !$past(clock_pm_capable) |-> !clock_pm_en)
    else $error("clock pm enable without capability");
  a_dll_sticky: assert property (
    dll_changed_flag && !dll_changed_clear |=> dll_changed_flag) else $error("change flag lost");
  a_msg_cause: assert property (
    lcl_wr && lcl_sel == 2'h2 && lcl_wdata[16:7] != slot_cap[16:7] |=> slot_power_msg)
    else $error("power message missing");
  a_msg_source: assert property (
    slot_power_msg |-> $past(lcl_wr) && $past(lcl_sel) == 2'h2)
    else $error("power message without write");
  a_slot_store: assert property (
    lcl_wr && lcl_sel == 2'h2 |=> slot_cap == $past(lcl_wdata)) else $error("slot word not stored");
  a_unmapped_zero: assert property (
    lcl_rd && lcl_sel == 2'h3 |=> lcl_rdata == 32'h0) else $error("unmapped read not zero");
  a_slotclk_local: assert property (
    cfg_wr && !lcl_wr |=> $stable(slot_clk_cfg)) else $error("link side changed slot clock");
  c_msg: cover property (slot_power_msg);
  c_retrain: cover property (retrain_pulse);
  c_dll: cover property ($rose(dll_changed_flag));
endmodule
bind link_slot_regs link_slot_regs_checker link_slot_regs_checker_i (.clk_sys, .reset_n,
  .root_port_mode, .lcl_sel, .lcl_wr, .lcl_rd, .lcl_wdata, .lcl_rdata, .cfg_wr,
  .clock_pm_capable, .dll_changed_clear, .dll_changed_flag, .retrain_pulse, .link_disable,
  .clock_pm_en, .rcb_128, .slot_clk_cfg, .slot_cap, .slot_power_msg);

/* File: sim/cfg_partner.sv */
// Link-side configuration requester model
`timescale 1ns/10ps
module cfg_partner (
  input wire logic clk_sys,
  output logic [1:0] cfg_sel,
  output logic cfg_wr,
  output logic cfg_rd,
  output logic [31:0] cfg_wdata,
  input wire logic [31:0] cfg_rdata
);
  // ----
  // Requests
  // ----
  initial begin
    cfg_sel = 2'h0;
    cfg_wr = 1'b0;
    cfg_rd = 1'b0;
    cfg_wdata = 32'h0;
  end
  // Caller keeps reserved bits and prohibited codes at zero
  task automatic req(input logic wr, input logic [1:0] sel, input logic [31:0] wd,
                     output logic [31:0] rd);
    @(negedge clk_sys);
    cfg_sel = sel;
    cfg_wdata = wd;
    cfg_wr = wr;
    cfg_rd = !wr;
    @(negedge clk_sys);
    rd = cfg_rdata;
    cfg_wr = 1'b0;
    cfg_rd = 1'b0;
    // Released data no longer shows the last word
    cfg_wdata = ~wd;
  endtask
endmodule

/* File: sim/tb_link_slot_regs.sv */
// Self-checking bench for the link and slot register bank
`timescale 1ns/10ps
module tb_link_slot_regs;
  logic clk_sys, reset_n, root_port_mode, lcl_wr, lcl_rd, cfg_wr, cfg_rd;
  logic [1:0] lcl_sel, cfg_sel, aspm_ctl;
  logic [31:0] lcl_wdata, lcl_rdata, cfg_wdata, cfg_rdata, slot_cap, rd;
  logic dl_active, link_training, clock_pm_capable, dll_changed_clear, dll_changed_flag;
  logic retrain_pulse, link_disable, ext_sync_en, common_clk_en, clock_pm_en, rcb_128;
  logic slot_clk_cfg, slot_power_msg;
  logic [5:0] negotiated_width;
  int n_fail = 0;
  int checked = 0;
  int n_msg = 0;
  link_slot_regs #(.INSTANCE(0)) link_slot_regs_i (.clk_sys, .reset_n, .root_port_mode,
    .lcl_sel, .lcl_wr, .lcl_rd, .lcl_wdata, .lcl_rdata, .cfg_sel, .cfg_wr, .cfg_rd,
    .cfg_wdata, .cfg_rdata, .dl_active, .link_training, .negotiated_width,
    .clock_pm_capable, .dll_changed_clear, .dll_changed_flag, .retrain_pulse,
    .link_disable, .ext_sync_en, .common_clk_en, .clock_pm_en, .aspm_ctl, .rcb_128,
    .slot_clk_cfg, .slot_cap, .slot_power_msg);
  cfg_partner cfg_partner_i (.clk_sys, .cfg_sel, .cfg_wr, .cfg_rd, .cfg_wdata, .cfg_rdata);
  // ----
  // Helpers
  // ----
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) if (slot_power_msg === 1'b1) n_msg++;
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic lcl(input logic wr, input logic [1:0] sel, input logic [31:0] wd);
    @(negedge clk_sys);
    lcl_sel = sel;
    lcl_wdata = wd;
    lcl_wr = wr;
    lcl_rd = !wr;
    @(negedge clk_sys);
    rd = lcl_rdata;
    lcl_wr = 1'b0;
    lcl_rd = 1'b0;
    lcl_wdata = ~wd;
  endtask
  task automatic rdl(input logic [1:0] sel, input logic [31:0] exp, input string nm);
    lcl(1'b0, sel, 32'h0);
    chk(nm, rd, exp);
  endtask
  task automatic summarize;
    $display("checked=%0d n_fail=%0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // ----
  // Tests
  // ----
  initial begin
    #50us;
    n_fail++;
    summarize();
  end
  initial begin
    {reset_n, lcl_wr, lcl_rd, lcl_sel, lcl_wdata} = '0;
    {dl_active, link_training, clock_pm_capable, dll_changed_clear} = 4'h8;
    root_port_mode = 1'b1;
    negotiated_width = 6'h01;
    repeat (6) @(negedge clk_sys);
    reset_n = 1'b1;
    rdl(2'h0, 32'h0002_0441, "link cap");
    rdl(2'h1, 32'h0011_0008, "link stat");
    rdl(2'h2, 32'h0, "slot cap");
    rdl(2'h3, 32'h0, "unmapped");
    chk("dll gated", 32'(dll_changed_flag), 32'h0);
    lcl(1'b1, 2'h1, 32'h1000_00f9);
    chk("retrain", 32'(retrain_pulse), 32'h1);
    chk("ctl outs", 32'({slot_clk_cfg, ext_sync_en, common_clk_en, link_disable, rcb_128,
      aspm_ctl}), 32'h7d);
    rdl(2'h1, 32'h1011_00d9, "stat back");
    @(negedge clk_sys) root_port_mode = 1'b0;
    @(negedge clk_sys);
    chk("endpoint", 32'({link_disable, rcb_128}), 32'h0);
    cfg_partner_i.req(1'b1, 2'h1, 32'h1000_0128, rd);
    chk("no retrain", 32'(retrain_pulse), 32'h0);
    rdl(2'h1, 32'h1011_0008, "cfg stat");
    chk("clk pm off", 32'(clock_pm_en), 32'h0);
    clock_pm_capable = 1'b1;
    cfg_partner_i.req(1'b1, 2'h1, 32'h0000_0100, rd);
    rdl(2'h1, 32'h1011_0100, "clk pm on");
    cfg_partner_i.req(1'b1, 2'h2, 32'hffff_ffff, rd);
    rdl(2'h2, 32'h0, "slot ro");
    n_msg = 0;
    lcl(1'b1, 2'h2, 32'h0001_ff80);
    lcl(1'b1, 2'h2, 32'h0001_ff80);
    lcl(1'b1, 2'h2, 32'hfffe_ff7f);
    repeat (2) @(negedge clk_sys);
    chk("msgs", 32'(n_msg), 32'h2);
    cfg_partner_i.req(1'b0, 2'h2, 32'h0, rd);
    chk("slot cfg", rd, 32'hfffe_ff7f);
    chk("slot out", slot_cap, 32'hfffe_ff7f);
    lcl(1'b1, 2'h0, 32'ha510_0000);
    rdl(2'h0, 32'ha516_0441, "cap bits");
    {dl_active, link_training} = 2'h3;
    negotiated_width = 6'h04;
    repeat (2) @(negedge clk_sys);
    chk("dll flag", 32'(dll_changed_flag), 32'h1);
    rdl(2'h1, 32'h3841_0100, "live stat");
    dll_changed_clear = 1'b1;
    @(negedge clk_sys) dll_changed_clear = 1'b0;
    chk("dll clear", 32'(dll_changed_flag), 32'h0);
    dl_active = 1'b0;
    repeat (2) @(negedge clk_sys);
    chk("dll fall", 32'(dll_changed_flag), 32'h1);
    {dl_active, dll_changed_clear} = 2'h3;
    @(negedge clk_sys) dll_changed_clear = 1'b0;
    chk("set wins", 32'(dll_changed_flag), 32'h1);
    clock_pm_capable = 1'b0;
    @(negedge clk_sys);
    chk("clk pm drop", 32'(clock_pm_en), 32'h0);
    summarize();
  end
endmodule
